/* design/lpi_phy_regs.svh */
`ifndef LPI_PHY_REGS_SVH
`define LPI_PHY_REGS_SVH

// Bus value while the link owns an idle bus
`define LPI_IDLE_BYTE        8'h00
// Command byte type field
`define LPI_CMD_TYPE_MSB     7
`define LPI_CMD_TYPE_LSB     6
`define LPI_CMD_SPECIAL      2'h0
`define LPI_CMD_TRANSMIT     2'h1
`define LPI_CMD_REG_WRITE    2'h2
`define LPI_CMD_REG_READ     2'h3
// Register address field of a command byte
`define LPI_CMD_ADDR_MSB     5
`define LPI_CMD_ADDR_LSB     0
// Receive status byte sent while no data is ready (receive active bit set)
`define LPI_RXCMD_ACTIVE     8'h10
// Data line that carries the isolate strap at reset release
`define LPI_STRAP_BIT        7
// Reset values
`define LPI_REG_RESET        8'h00
`define LPI_CLOCK_ON_RESET   1'b1
// Interface clock rate, MHz
`define LPI_LINK_CLOCK_MHZ   60

`endif

/* design/lpi_phy_pkg.sv */
package lpi_phy_pkg;

  // One byte on its way across a clock crossing
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } byte_word_t;

  // What the device drives onto the bus side
  typedef struct packed {
    logic       dir;
    logic       nxt;
    logic       oe;
    logic [7:0] data;
  } bus_drive_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_CMD,
    ST_TX,
    ST_TX_END,
    ST_REGW,
    ST_RD_TURN,
    ST_RD_DATA,
    ST_RX,
    ST_RX_LAST,
    ST_TURN_BACK,
    ST_LOW_POWER
  } port_state_t;

endpackage : lpi_phy_pkg

/* design/lpi_bit_sync.sv */
`timescale 1ns/1ps
module lpi_bit_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : lpi_bit_sync

/* design/lpi_phy_link_port.sv */
// What this block does
// - The device alone decides bus direction; the link only follows.
// - Device supplies the 60 MHz interface clock; all bus logic runs on it.
// - In low-power mode the interface clock is not driven.
// - One byte per cycle, launched and taken on the rising clock edge.
// - Direction low: link drives data; high: device drives data.
// - Next paces all data except register read data and receive status bytes.
// - Receive activity starts with direction and next rising together.
// - Next stays low in the first cycle of a link command byte.
// - Isolate strap latched at reset release; this port keeps working when isolated.
`timescale 1ns/1ps
`include "lpi_phy_regs.svh"
module lpi_phy_link_port
  import lpi_phy_pkg::*;
#(
  parameter int REG_ADDR_W = 6
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       clk_link,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            bus_direction,
  output logic            phy_next_throttle,
  input  wire logic       link_stop,
  output logic            interface_clock_60m_oe,
  output logic            pipe_isolate,
  input  wire logic       low_power_req,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_last,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  output logic      [7:0] tx_byte,
  output logic            tx_last,
  output logic            tx_valid
);

  localparam int REG_DEPTH = 2 ** REG_ADDR_W;

  // ---------------- Core domain (clk_sys) ----------------
  byte_word_t rx_hold_reg;
  logic       rx_req_reg;
  logic       rx_ready_reg;
  logic       rx_ack_sync;
  logic       tx_req_sync;
  logic       tx_seen_reg;
  byte_word_t tx_out_reg;
  logic       tx_valid_reg;

  // ---------------- Link domain (clk_link) ----------------
  port_state_t     state_reg;
  port_state_t     state_next;
  bus_drive_t      drive_reg;
  bus_drive_t      drive_next;
  logic [7:0]      cmd_reg;
  logic [7:0]      cmd_next;
  logic            clk_oe_reg;
  logic            clk_oe_next;
  logic            strap_done_reg;
  logic            isolate_reg;
  logic            rx_seen_reg;
  logic            rx_req_sync;
  logic            tx_req_reg;
  byte_word_t      tx_hold_reg;
  byte_word_t      tx_word_next;
  logic            tx_send;
  logic            tx_ack_sync;
  logic            lp_sync;
  logic            rx_pop;
  logic            mem_we;
  logic [7:0]      reg_mem [0:REG_DEPTH-1];

  wire             rx_pending = (rx_req_sync != rx_seen_reg);
  wire             tx_free    = (tx_ack_sync == tx_req_reg);
  wire [1:0]       cmd_type   = cmd_reg[`LPI_CMD_TYPE_MSB:`LPI_CMD_TYPE_LSB];
  wire [REG_ADDR_W-1:0] reg_addr = cmd_reg[REG_ADDR_W-1:`LPI_CMD_ADDR_LSB];
  wire [7:0]       reg_rdata  = reg_mem[reg_addr];
  // Strap value on the bus at release is not a command
  wire             bus_busy   = strap_done_reg && (data_in != `LPI_IDLE_BYTE);
  wire byte_word_t rx_word    = rx_hold_reg;

  // ---------------- Crossings ----------------
  lpi_bit_sync #(.WIDTH(1)) u_lp_sync     (.clk(clk_link), .rst(rst), .d(low_power_req), .q(lp_sync));
  lpi_bit_sync #(.WIDTH(1)) u_rx_req_sync (.clk(clk_link), .rst(rst), .d(rx_req_reg), .q(rx_req_sync));
  lpi_bit_sync #(.WIDTH(1)) u_tx_ack_sync (.clk(clk_link), .rst(rst), .d(tx_seen_reg), .q(tx_ack_sync));
  lpi_bit_sync #(.WIDTH(1)) u_rx_ack_sync (.clk(clk_sys), .rst(rst), .d(rx_seen_reg), .q(rx_ack_sync));
  lpi_bit_sync #(.WIDTH(1)) u_tx_req_sync (.clk(clk_sys), .rst(rst), .d(tx_req_reg), .q(tx_req_sync));

  // ---------------- Core side: receive bytes in ----------------
  // Hold word stays still until the link side acknowledges it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_hold_reg  <= '0;
      rx_req_reg   <= 1'b0;
      rx_ready_reg <= 1'b1;
    end else if (rx_valid && rx_ready_reg) begin
      rx_hold_reg  <= '{last: rx_last, data: rx_byte};
      rx_req_reg   <= ~rx_req_reg;
      rx_ready_reg <= 1'b0;
    end else if (rx_ack_sync == rx_req_reg) begin
      rx_ready_reg <= 1'b1;
    end
  end

  // ---------------- Core side: transmit bytes out ----------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_seen_reg  <= 1'b0;
      tx_out_reg   <= '0;
      tx_valid_reg <= 1'b0;
    end else begin
      tx_valid_reg <= (tx_req_sync != tx_seen_reg);
      if (tx_req_sync != tx_seen_reg) begin
        tx_seen_reg <= tx_req_sync;
        tx_out_reg  <= tx_hold_reg;
      end
    end
  end

  assign rx_ready = rx_ready_reg;
  assign tx_byte  = tx_out_reg.data;
  assign tx_last  = tx_out_reg.last;
  assign tx_valid = tx_valid_reg;

  // ---------------- Bus state machine (clk_link) ----------------
  // Outputs are registered, so next only rises the cycle after a command
  // byte is first seen: the first command cycle never sees it high.
  always_comb begin
    state_next   = state_reg;
    drive_next   = '{dir: 1'b0, nxt: 1'b0, oe: 1'b0, data: `LPI_IDLE_BYTE};
    cmd_next     = cmd_reg;
    clk_oe_next  = 1'b1;
    tx_send      = 1'b0;
    tx_word_next = tx_hold_reg;
    rx_pop       = 1'b0;
    mem_we       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (lp_sync) begin
          clk_oe_next = 1'b0;
          state_next  = ST_LOW_POWER;
        end else if (bus_busy) begin
          cmd_next       = data_in;
          drive_next.nxt = 1'b1;
          state_next     = ST_CMD;
        end else if (rx_pending) begin
          drive_next.dir = 1'b1;
          drive_next.nxt = 1'b1;
          state_next     = ST_RX;
        end
      end
      ST_CMD: begin
        case (cmd_type)
          `LPI_CMD_TRANSMIT: begin
            drive_next.nxt = tx_free;
            state_next     = ST_TX;
          end
          `LPI_CMD_REG_WRITE: begin
            drive_next.nxt = 1'b1;
            state_next     = ST_REGW;
          end
          `LPI_CMD_REG_READ: begin
            drive_next.dir = 1'b1;
            state_next     = ST_RD_TURN;
          end
          default: state_next = ST_IDLE;
        endcase
      end
      ST_TX: begin
        if (link_stop) begin
          state_next = ST_TX_END;
        end else if (drive_reg.nxt) begin
          tx_send      = 1'b1;
          tx_word_next = '{last: 1'b0, data: data_in};
        end else begin
          drive_next.nxt = tx_free;
        end
      end
      ST_TX_END: begin
        // End marker waits for a free crossing; link holds its next command
        if (tx_free) begin
          tx_send      = 1'b1;
          tx_word_next = '{last: 1'b1, data: `LPI_IDLE_BYTE};
          state_next   = ST_IDLE;
        end
      end
      ST_REGW: begin
        if (link_stop) begin
          state_next = ST_IDLE;
        end else if (drive_reg.nxt) begin
          mem_we = 1'b1;
        end
      end
      ST_RD_TURN: begin
        drive_next = '{dir: 1'b1, nxt: 1'b0, oe: 1'b1, data: reg_rdata};
        state_next = ST_RD_DATA;
      end
      ST_RD_DATA: state_next = ST_TURN_BACK;
      ST_RX: begin
        drive_next.dir = 1'b1;
        drive_next.oe  = 1'b1;
        if (rx_pending) begin
          drive_next.nxt  = 1'b1;
          drive_next.data = rx_word.data;
          rx_pop          = 1'b1;
          if (rx_word.last) begin
            state_next = ST_RX_LAST;
          end
        end else begin
          drive_next.data = `LPI_RXCMD_ACTIVE;
        end
      end
      ST_RX_LAST:   state_next = ST_TURN_BACK;
      ST_TURN_BACK: state_next = ST_IDLE;
      ST_LOW_POWER: begin
        if (lp_sync) begin
          clk_oe_next = 1'b0;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      drive_reg  <= '{dir: 1'b0, nxt: 1'b0, oe: 1'b0, data: `LPI_IDLE_BYTE};
      cmd_reg    <= `LPI_IDLE_BYTE;
      clk_oe_reg <= `LPI_CLOCK_ON_RESET;
    end else begin
      state_reg  <= state_next;
      drive_reg  <= drive_next;
      cmd_reg    <= cmd_next;
      clk_oe_reg <= clk_oe_next;
    end
  end

  // Crossing toggles and the word they carry
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      tx_req_reg  <= 1'b0;
      tx_hold_reg <= '0;
      rx_seen_reg <= 1'b0;
    end else begin
      if (tx_send) begin
        tx_req_reg  <= ~tx_req_reg;
        tx_hold_reg <= tx_word_next;
      end
      if (rx_pop) begin
        rx_seen_reg <= rx_req_sync;
      end
    end
  end

  // Internal register bytes written and read over the bus
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        reg_mem[i] <= `LPI_REG_RESET;
      end
    end else if (mem_we) begin
      reg_mem[reg_addr] <= data_in;
    end
  end

  // Strap taken on the first edge after release; isolate never gates this port
  always_ff @(posedge clk_link or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      isolate_reg    <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      isolate_reg    <= data_in[`LPI_STRAP_BIT];
    end
  end

  assign data_out               = drive_reg.data;
  assign data_oe                = drive_reg.oe;
  assign bus_direction          = drive_reg.dir;
  assign phy_next_throttle      = drive_reg.nxt;
  assign interface_clock_60m_oe = clk_oe_reg;
  assign pipe_isolate           = isolate_reg;

endmodule : lpi_phy_link_port

/* testbench/lpi_phy_link_port_properties.sv */
`timescale 1ns/1ps
module lpi_phy_link_port_properties #(
  parameter int REG_ADDR_W = 6
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       clk_link,
  input wire logic [7:0] data_in,
  input wire logic       data_oe,
  input wire logic       bus_direction,
  input wire logic       phy_next_throttle,
  input wire logic       interface_clock_60m_oe,
  input wire logic       pipe_isolate,
  input wire logic       tx_valid
);
  logic strap_bit;
  assign strap_bit = data_in[7];
  // Zero-to-nonzero on an idle bus marks a fresh command byte
  sequence new_cmd;
    !bus_direction && !$past(bus_direction) && data_in != 8'h00 && $past(data_in) == 8'h00
      && !$past(phy_next_throttle);
  endsequence
  a_oe_needs_dir: assert property (@(posedge clk_link) disable iff (rst) data_oe |-> bus_direction)
    else $error("data driven with direction low");
  a_rise_turn: assert property (@(posedge clk_link) disable iff (rst) $rose(bus_direction) |-> !data_oe)
    else $error("no turnaround on direction rise");
  a_fall_turn: assert property (@(posedge clk_link) disable iff (rst) $fell(bus_direction) |-> !data_oe)
    else $error("no turnaround on direction fall");
  a_cmd_first_quiet: assert property (@(posedge clk_link) disable iff (rst)
    new_cmd |-> !phy_next_throttle ##1 phy_next_throttle) else $error("next wrong around command");
  a_rx_start_pair: assert property (@(posedge clk_link) disable iff (rst)
    ($rose(bus_direction) && phy_next_throttle) |=> data_oe) else $error("receive start not followed by data");
  a_read_unthrottled: assert property (@(posedge clk_link) disable iff (rst)
    ($rose(bus_direction) && !phy_next_throttle) |=> data_oe && !phy_next_throttle ##1 !bus_direction)
    else $error("read data cycle wrong");
  a_lp_quiet: assert property (@(posedge clk_link) disable iff (rst)
    !interface_clock_60m_oe |-> !bus_direction && !data_oe && !phy_next_throttle) else $error("bus active in low power");
  a_strap_latch: assert property (@(posedge clk_link) disable iff (rst)
    ($past(rst, 2) && !$past(rst)) |-> pipe_isolate == $past(strap_bit)) else $error("strap not latched");
  a_strap_hold: assert property (@(posedge clk_link) disable iff (rst)
    (!$past(rst, 2) && !$past(rst)) |-> $stable(pipe_isolate)) else $error("strap changed");
  a_tx_pulse: assert property (@(posedge clk_sys) disable iff (rst) tx_valid |=> !tx_valid)
    else $error("tx_valid longer than one cycle");
  c_read: cover property (@(posedge clk_link) disable iff (rst) $rose(bus_direction) && !phy_next_throttle);
  c_rx: cover property (@(posedge clk_link) disable iff (rst) $rose(bus_direction) && phy_next_throttle);
  c_lp: cover property (@(posedge clk_link) disable iff (rst) $fell(interface_clock_60m_oe));
endmodule : lpi_phy_link_port_properties
bind lpi_phy_link_port lpi_phy_link_port_properties #(.REG_ADDR_W(REG_ADDR_W)) props_inst (.clk_sys(clk_sys),
  .rst(rst), .clk_link(clk_link), .data_in(data_in), .data_oe(data_oe), .bus_direction(bus_direction),
  .phy_next_throttle(phy_next_throttle), .interface_clock_60m_oe(interface_clock_60m_oe),
  .pipe_isolate(pipe_isolate), .tx_valid(tx_valid));

/* testbench/lpi_link_model.sv */
`timescale 1ns/1ps
module lpi_link_model (
  input  wire logic       clk_link,
  input  wire logic       rst,
  input  wire logic       bus_direction,
  input  wire logic       phy_next_throttle,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic      [7:0] data_in,
  output logic            link_stop
);
  logic [7:0] drv = 8'h80;
  logic [7:0] rxq[$];
  initial link_stop = 1'b0;
  // Pull-down wins whenever nobody drives
  assign data_in = data_oe ? data_out : (bus_direction ? 8'h00 : drv);
  initial begin
    @(negedge rst);
    @(posedge clk_link) #1;
    drv = 8'h00;
  end
  always @(posedge clk_link) if (bus_direction && data_oe && phy_next_throttle) rxq.push_back(data_out);
  // Holds the byte until next is seen at an edge
  task automatic send(input logic [7:0] v);
    int n = 0;
    drv = v;
    while (!phy_next_throttle && n < 50) begin
      @(posedge clk_link) #1;
      n++;
    end
    @(posedge clk_link) #1;
  endtask : send
  task automatic stop;
    drv = 8'h00;
    link_stop = 1'b1;
    @(posedge clk_link) #1;
    link_stop = 1'b0;
  endtask : stop
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_link) #1;
    send({2'h2, a});
    send(d);
    stop();
  endtask : reg_write
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    int n = 0;
    @(posedge clk_link) #1;
    send({2'h3, a});
    drv = 8'h00;
    while (!(bus_direction && data_oe) && n < 20) begin
      @(posedge clk_link) #1;
      n++;
    end
    d = data_in;
    while (bus_direction && n < 40) begin
      @(posedge clk_link) #1;
      n++;
    end
    @(posedge clk_link) #1;
  endtask : reg_read
  task automatic transmit;
    @(posedge clk_link) #1;
    send(8'h41);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    stop();
  endtask : transmit
endmodule : lpi_link_model

/* testbench/lpi_phy_link_port_test.sv */
`timescale 1ns/1ps
module lpi_phy_link_port_test;
  import lpi_phy_pkg::*;
  logic       clk_sys = 0, clk_link = 0, rst = 1, low_power_req = 0, rx_last = 0, rx_valid = 0;
  logic [7:0] rx_byte = 8'h00, data_in, data_out, tx_byte, rd;
  logic       data_oe, bus_direction, phy_next_throttle, link_stop, clk_oe, pipe_isolate, rx_ready, tx_last, tx_valid;
  byte_word_t txq[$];
  int         bad_count = 0, tests_run = 0;
  lpi_phy_link_port lpi_phy_link_port_inst (.clk_sys(clk_sys), .rst(rst), .clk_link(clk_link), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .bus_direction(bus_direction), .phy_next_throttle(phy_next_throttle),
    .link_stop(link_stop), .interface_clock_60m_oe(clk_oe), .pipe_isolate(pipe_isolate),
    .low_power_req(low_power_req), .rx_byte(rx_byte), .rx_last(rx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_valid(tx_valid));
  lpi_link_model lpi_link_model_inst (.clk_link(clk_link), .rst(rst), .bus_direction(bus_direction),
    .phy_next_throttle(phy_next_throttle), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
    .link_stop(link_stop));
  initial forever #25 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #80 clk_link = ~clk_link;
  end
  always @(posedge clk_sys) if (tx_valid) txq.push_back('{tx_last, tx_byte});
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up;
    $display("comparisons=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic t_reset;
    repeat (20) @(posedge clk_sys);
    check({data_oe, bus_direction, phy_next_throttle, clk_oe, rx_ready, tx_valid}, 16'h0006);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_link);
    check(pipe_isolate, 16'h0001);
    $display("reset test done");
  endtask : t_reset
  task automatic t_reg;
    logic [5:0] a [3] = '{6'h00, 6'h3F, 6'h15};
    foreach (a[i]) lpi_link_model_inst.reg_write(a[i], {2'h2, a[i]} ^ 8'hFF);
    foreach (a[i]) begin
      lpi_link_model_inst.reg_read(a[i], rd);
      check(rd, {2'h2, a[i]} ^ 8'hFF);
    end
    $display("register test done");
  endtask : t_reg
  task automatic t_tx;
    logic [8:0] e [4] = '{9'h011, 9'h022, 9'h033, 9'h100};
    int n = 0;
    lpi_link_model_inst.transmit();
    while ((txq.size() == 0 || !txq[$].last) && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    for (int i = 0; i < 4; i++) check(txq[txq.size() - 4 + i], e[i]);
    $display("transmit test done");
  endtask : t_tx
  task automatic core_send(input logic [7:0] b, input logic l);
    int n = 0;
    rx_byte = b;
    rx_last = l;
    rx_valid = 1'b1;
    while (!rx_ready && n < 100) begin
      @(posedge clk_sys) #1;
      n++;
    end
    @(posedge clk_sys) #1;
  endtask : core_send
  task automatic t_rx;
    int         n = 0;
    logic [7:0] e [3] = '{8'hA5, 8'h5A, 8'hC3};
    @(posedge clk_sys) #1;
    core_send(8'hA5, 1'b0);
    core_send(8'h5A, 1'b0);
    core_send(8'hC3, 1'b1);
    rx_valid = 1'b0;
    while ((lpi_link_model_inst.rxq.size() < 3 || bus_direction) && n < 200) begin
      @(posedge clk_link) #1;
      n++;
    end
    check(n < 200, 16'h0001);
    check(lpi_link_model_inst.rxq.size(), 16'h0003);
    foreach (lpi_link_model_inst.rxq[i]) check(lpi_link_model_inst.rxq[i], e[i]);
    $display("receive test done");
  endtask : t_rx
  task automatic t_lp;
    int n = 0;
    @(posedge clk_link) #1 low_power_req = 1'b1;
    while (clk_oe && n < 30) begin
      @(posedge clk_link) #1;
      n++;
    end
    check(clk_oe, 16'h0000);
    #1 low_power_req = 1'b0;
    while (!clk_oe && n < 60) begin
      @(posedge clk_link) #1;
      n++;
    end
    check(clk_oe, 16'h0001);
    lpi_link_model_inst.reg_read(6'h3F, rd);
    check(rd, 16'h0040);
    $display("low power test done");
  endtask : t_lp
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
  initial begin
    t_reset();
    t_reg();
    t_tx();
    t_rx();
    t_lp();
    wrap_up();
  end
endmodule : lpi_phy_link_port_test
